// >>> lwk_link_wake.sv
// link wake notification generator with port mode strap capture
//
// Summary of operation
// R1 - wake output square wave, eight clocks period
// R2 - low when idle, undriven during reset
// R3 - link inactive: power status off or control clear
// R4 - own link-on packet starts wake
// R5 - port event irq starts wake
// R6 - timeout/power irqs with resume enable start wake
// R7 - power cycle with class 0..4 starts wake
// R8 - wake holds until link becomes active
// R9 - bus reset drops packet-only wake
// R10 - power-cycle wake ends after 167 us
// R11 - pending irq wakes once link goes inactive
// R12 - sample mode straps 3 and 4 at reset
// R13 - sel5 pin: strap in reset, then wake out
// R14 - default power class from straps by mode
// R15 - toggle every four clocks, start low
`timescale 1ns/100ps
`default_nettype none

module lwk_link_wake #(
	parameter int PWR_TIMEOUT_CYC = lwk_pkg::PWR_TIMEOUT_CYC      // shorten for simulation
) (
	// clock and reset
	input  wire logic                        CLK,
	input  wire logic                        RST_N,
	// register port
	input  wire logic [lwk_pkg::ADDR_W-1:0]  ADDR,
	input  wire logic [lwk_pkg::DATA_W-1:0]  WDATA,
	input  wire logic                        WR,
	input  wire logic                        RD,
	output logic      [lwk_pkg::DATA_W-1:0]  RDATA,
	output logic                             IRQ,
	// strap pins, asynchronous
	input  wire logic                        PORT_MODE_SEL_BIT3,
	input  wire logic                        PORT_MODE_SEL_BIT4,
	input  wire logic                        MODE_SEL2_POWER_CLASS0,
	input  wire logic                        MODE_SEL1_POWER_CLASS1,
	input  wire logic                        MODE_SEL0_POWER_CLASS2,
	// shared sel5 / wake pin
	input  wire logic                        MODE_SEL5_WAKE_IN,
	output logic                             MODE_SEL5_WAKE_OUT,
	output logic                             MODE_SEL5_WAKE_OE,
	// link power status pin, asynchronous
	input  wire logic                        LINK_POWER_STATUS,
	// wake causes from the phy core, same clock
	input  wire logic                        LINK_ON_PKT,
	input  wire logic                        BUS_RESET,
	input  wire logic                        PORT_EVENT_IRQ,
	input  wire logic                        CONFIG_TIMEOUT_IRQ,
	input  wire logic                        CABLE_POWER_STATUS_IRQ,
	input  wire logic                        STATE_TIMEOUT_IRQ,
	// captured strap results
	output logic      [5:0]                  PORT_MODE_STRAP,
	output logic      [2:0]                  POWER_CLASS
);

	// ****************************************
	// local constants
	// ****************************************
	localparam int         PCW      = $clog2(PWR_TIMEOUT_CYC + 1);   // timeout counter width
	localparam logic [PCW-1:0] PWR_LAST = PCW'(PWR_TIMEOUT_CYC - 1); // last count of timeout
	localparam int         DVW      = $clog2(lwk_pkg::WAKE_HALF_CYC); // half period counter width
	localparam logic [DVW-1:0] DIV_LAST = DVW'(lwk_pkg::WAKE_HALF_CYC - 1);
	localparam logic [1:0] STRAP_LAST = 2'(lwk_pkg::STRAP_WAIT_CYC - 1);
	localparam int         PIN_W    = 7;                             // synchronised pin count

	// ****************************************
	// reset release
	// ****************************************
	logic rst_meta_r;                                               // first stage, read only by next
	logic rst_n;                                                    // released internal reset

	// assert at once, release two edges later so no flop sees a runt release
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [PIN_W-1:0] pin_raw;                                      // pins as they arrive
	logic [PIN_W-1:0] pin_meta_r;                                   // first stage
	logic [PIN_W-1:0] pin_sync_r;                                   // safe copy
	logic             lps_s;                                        // synchronised power status

	assign pin_raw = {LINK_POWER_STATUS, MODE_SEL5_WAKE_IN, PORT_MODE_SEL_BIT4,
			PORT_MODE_SEL_BIT3, MODE_SEL2_POWER_CLASS0, MODE_SEL1_POWER_CLASS1,
			MODE_SEL0_POWER_CLASS2};
	assign lps_s   = pin_sync_r[6];

	// two flops on every pin before any logic looks at it
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
		end
	end

	// ****************************************
	// register state
	// ****************************************
	logic [1:0]              ctrl_r;                                // control bits
	logic [lwk_pkg::EV_W-1:0] isr_r;                                // sticky events
	logic [lwk_pkg::EV_W-1:0] imr_r;                                // event mask
	logic [lwk_pkg::DATA_W-1:0] rdata_r;                            // registered read data

	// ****************************************
	// strap capture
	// ****************************************
	logic [1:0] strap_cnt_r;                                        // wait for synchroniser to fill
	logic       strap_done_r;                                       // straps frozen
	logic [5:0] mode_r;                                             // sel5..sel0 as strapped
	logic [2:0] pc_r;                                               // default power class
	logic       strap_take;                                         // capture cycle
	logic [2:0] pc_pins;                                            // class pins, pc0 first
	logic [2:0] pc_pick;                                            // class by mode

	assign strap_take = !strap_done_r && (strap_cnt_r == STRAP_LAST);
	assign pc_pins    = pin_sync_r[2:0];
	// modes with sel4 and sel3 both set force class zero
	assign pc_pick    = (pin_sync_r[4:3] == lwk_pkg::SEL43_FORCE) ? lwk_pkg::PC_FORCED
			: pc_pins;                                      // R14

	// pins are sampled once, just after reset release, while the sel5 pin is still undriven
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			strap_cnt_r  <= 2'h0;
			strap_done_r <= 1'b0;
			mode_r       <= 6'h00;
			pc_r         <= 3'h0;
		end else if (strap_take) begin
			strap_done_r <= 1'b1;
			mode_r       <= pin_sync_r[5:0];                    // R12 R13
			pc_r         <= pc_pick;                            // R14
		end else if (!strap_done_r) begin
			strap_cnt_r  <= strap_cnt_r + 2'h1;
		end
	end

	// ****************************************
	// wake causes
	// ****************************************
	logic       link_active;                                        // link layer up
	logic       irq_cause;                                          // enabled interrupt cause
	logic       pkt_r;                                              // link-on packet pending
	logic       pwr_r;                                              // power-cycle wake pending
	logic [PCW-1:0] pwr_cnt_r;                                      // power-cycle wake age
	logic       pwr_timeout;                                        // 167 us reached
	logic       any_cause;                                          // anything asks for wake

	assign link_active = lps_s && ctrl_r[lwk_pkg::CTRL_LINK_CTL];  // R3
	assign irq_cause   = PORT_EVENT_IRQ                             // R5
			|| (ctrl_r[lwk_pkg::CTRL_RESUME_EN]                     // R6
			&& (CONFIG_TIMEOUT_IRQ || CABLE_POWER_STATUS_IRQ || STATE_TIMEOUT_IRQ));
	assign pwr_timeout = pwr_r && (pwr_cnt_r == PWR_LAST);          // R10
	assign any_cause   = irq_cause || pkt_r || pwr_r;

	// packet cause: kept only while link is down, dropped by bus reset
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pkt_r <= 1'b0;
		end else if (link_active || BUS_RESET) begin
			pkt_r <= 1'b0;                                      // R9
		end else if (LINK_ON_PKT && strap_done_r) begin
			pkt_r <= 1'b1;                                      // R4
		end
	end

	// power-cycle cause: every hardware reset counts as a power cycle
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pwr_r     <= 1'b0;
			pwr_cnt_r <= '0;
		end else if (strap_take) begin
			pwr_r     <= (pc_pick <= lwk_pkg::PC_MAX_WAKE);     // R7
			pwr_cnt_r <= '0;
		end else if (link_active || pwr_timeout) begin
			pwr_r     <= 1'b0;                                  // R10
		end else if (pwr_r) begin
			pwr_cnt_r <= pwr_cnt_r + PCW'(1);
		end
	end

	// ****************************************
	// wake state machine
	// ****************************************
	lwk_pkg::lwk_state_t st_r;                                      // current state
	lwk_pkg::lwk_state_t st_nxt;                                    // next state
	logic       wake_stop;                                          // leave wake this cycle

	// a cleared irq does not stop the wave; only link-up or a cause-specific end does
	assign wake_stop = link_active                                 // R8
			|| (BUS_RESET && !irq_cause && !pwr_r)                  // R9
			|| (pwr_timeout && !irq_cause && !pkt_r);               // R10

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			lwk_pkg::ST_STRAP: begin
				if (strap_done_r) begin
					st_nxt = lwk_pkg::ST_IDLE;
				end
			end
			lwk_pkg::ST_IDLE: begin
				// level causes make a pending irq fire once link drops
				if (!link_active && any_cause) begin     // R3 R11
					st_nxt = lwk_pkg::ST_WAKE;
				end
			end
			lwk_pkg::ST_WAKE: begin
				if (wake_stop) begin
					st_nxt = lwk_pkg::ST_IDLE;
				end
			end
			default: begin
				st_nxt = lwk_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= lwk_pkg::ST_STRAP;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// square wave
	// ****************************************
	logic [DVW-1:0] div_r;                                          // half period count
	logic           wave_r;                                         // pin level
	logic           oe_r;                                           // pin drive
	logic           running;                                        // stays in wake

	assign running = (st_r == lwk_pkg::ST_WAKE) && (st_nxt == lwk_pkg::ST_WAKE);

	// restart from low on every entry so the first half period is whole
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			div_r  <= '0;
			wave_r <= 1'b0;
		end else if (!running) begin
			div_r  <= '0;
			wave_r <= 1'b0;                                     // R2 R15
		end else if (div_r == DIV_LAST) begin
			div_r  <= '0;
			wave_r <= !wave_r;                                  // R1 R15
		end else begin
			div_r  <= div_r + DVW'(1);
		end
	end

	// pin stays released through reset and strap sampling
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			oe_r <= 1'b0;                                       // R2
		end else begin
			oe_r <= strap_done_r;                               // R13
		end
	end

	// ****************************************
	// events
	// ****************************************
	logic [lwk_pkg::EV_W-1:0] ev;                                   // one-cycle event pulses

	assign ev[lwk_pkg::EV_START]   = (st_r == lwk_pkg::ST_IDLE) && (st_nxt == lwk_pkg::ST_WAKE);
	assign ev[lwk_pkg::EV_STOP]    = (st_r == lwk_pkg::ST_WAKE) && (st_nxt == lwk_pkg::ST_IDLE);
	assign ev[lwk_pkg::EV_TIMEOUT] = pwr_timeout && !link_active;

	// ****************************************
	// register port
	// ****************************************
	logic                       wr_ctrl;                            // control write
	logic                       wr_isr;                             // status clear write
	logic                       wr_imr;                             // mask write
	logic [lwk_pkg::DATA_W-1:0] stat_word;                          // live status
	logic [lwk_pkg::DATA_W-1:0] rd_mux;                             // selected read word

	assign wr_ctrl = WR && (ADDR == lwk_pkg::OFS_CTRL);
	assign wr_isr  = WR && (ADDR == lwk_pkg::OFS_ISR);
	assign wr_imr  = WR && (ADDR == lwk_pkg::OFS_IMR);

	assign stat_word = {17'h00000, pkt_r, pwr_r, strap_done_r, mode_r, pc_r, lps_s,
			link_active, (st_r == lwk_pkg::ST_WAKE)};

	// unmapped addresses read zero
	assign rd_mux = (ADDR == lwk_pkg::OFS_CTRL) ? {30'h00000000, ctrl_r}
			: (ADDR == lwk_pkg::OFS_STAT) ? stat_word
			: (ADDR == lwk_pkg::OFS_ISR)  ? {29'h00000000, isr_r}
			: (ADDR == lwk_pkg::OFS_IMR)  ? {29'h00000000, imr_r}
			: 32'h00000000;

	// control and mask writes
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= lwk_pkg::CTRL_RESET;
			imr_r  <= lwk_pkg::EV_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= WDATA[1:0];
			end
			if (wr_imr) begin
				imr_r <= WDATA[lwk_pkg::EV_W-1:0];
			end
		end
	end

	// sticky events: a new event beats a clear in the same cycle
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			isr_r <= lwk_pkg::EV_RESET;
		end else begin
			isr_r <= (isr_r & ~(wr_isr ? WDATA[lwk_pkg::EV_W-1:0] : 3'h0)) | ev;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 32'h00000000;
		end else begin
			rdata_r <= RD ? rd_mux : 32'h00000000;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign RDATA              = rdata_r;
	assign IRQ                = |(isr_r & imr_r);
	assign MODE_SEL5_WAKE_OUT = wave_r;
	assign MODE_SEL5_WAKE_OE  = oe_r;
	assign PORT_MODE_STRAP    = mode_r;
	assign POWER_CLASS        = pc_r;

endmodule : lwk_link_wake

`default_nettype wire

// >>> lwk_pkg.sv
// constants shared by the link wake and port mode strap block
`default_nettype none

package lwk_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_PERIOD_NS   = 40;                          // 25 MHz core clock
	localparam int WAKE_PERIOD_CYC = 8;                           // wake square wave period
	localparam int WAKE_HALF_CYC   = WAKE_PERIOD_CYC / 2;         // cycles per half period
	localparam int PWR_TIMEOUT_NS  = 167000;                      // power-cycle wake limit, 167 us
	localparam int PWR_TIMEOUT_CYC = PWR_TIMEOUT_NS / CLK_PERIOD_NS; // longest time, rounds down
	localparam int STRAP_WAIT_CYC  = 3;                           // lets the pin synchroniser fill

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam int          ADDR_W   = 8;                         // register address width
	localparam int          DATA_W   = 32;                        // register data width
	localparam logic [7:0]  OFS_CTRL = 8'h00;                     // control
	localparam logic [7:0]  OFS_STAT = 8'h04;                     // live status, read only
	localparam logic [7:0]  OFS_ISR  = 8'h08;                     // sticky events, write one to clear
	localparam logic [7:0]  OFS_IMR  = 8'h0C;                     // event mask, one enables

	// ****************************************
	// control fields
	// ****************************************
	localparam int          CTRL_LINK_CTL   = 0;                  // link control bit
	localparam int          CTRL_RESUME_EN  = 1;                  // resuming port irq enable
	localparam logic [1:0]  CTRL_RESET      = 2'h0;               // both clear after reset

	// ****************************************
	// status fields
	// ****************************************
	localparam int STAT_WAKE    = 0;                              // wake notification active
	localparam int STAT_LINK    = 1;                              // link layer seen active
	localparam int STAT_LPS     = 2;                              // synchronised power status
	localparam int STAT_PC_LO   = 3;                              // power class, 3 bits
	localparam int STAT_MODE_LO = 6;                              // strap sel5..sel0, 6 bits
	localparam int STAT_STRAPPED= 12;                             // straps captured
	localparam int STAT_PWR     = 13;                             // power-cycle cause pending
	localparam int STAT_PKT     = 14;                             // link-on packet cause pending

	// ****************************************
	// event bits (status and mask share this layout)
	// ****************************************
	localparam int          EV_W        = 3;                      // number of events
	localparam int          EV_START    = 0;                      // wake output started
	localparam int          EV_STOP     = 1;                      // wake output stopped
	localparam int          EV_TIMEOUT  = 2;                      // power-cycle wake timed out
	localparam logic [2:0]  EV_RESET    = 3'h0;                   // no events after reset

	// ****************************************
	// strap decode
	// ****************************************
	localparam logic [2:0]  PC_MAX_WAKE = 3'h4;                   // classes 0..4 wake on power-up
	localparam logic [2:0]  PC_FORCED   = 3'h0;                   // class when sel4 and sel3 set
	localparam logic [1:0]  SEL43_FORCE = 2'h3;                   // sel4,sel3 pattern forcing class

	// ****************************************
	// wake state machine
	// ****************************************
	typedef enum logic [1:0] {
		ST_STRAP,                                             // pin released, straps settling
		ST_IDLE,                                              // driven low
		ST_WAKE                                               // square wave running
	} lwk_state_t;

endpackage : lwk_pkg

`default_nettype wire

// >>> lwk_link_wake_props.sv
// assertion checker for the link wake block
`timescale 1ns/100ps
`default_nettype none

module lwk_link_wake_props #(
	parameter int PWR_TIMEOUT_CYC = lwk_pkg::PWR_TIMEOUT_CYC // same count as the design
) (
	// clock, reset and register port
	input wire logic                       CLK,
	input wire logic                       RST_N,
	input wire logic [lwk_pkg::ADDR_W-1:0] ADDR,
	input wire logic [lwk_pkg::DATA_W-1:0] WDATA,
	input wire logic                       WR,
	input wire logic                       RD,
	input wire logic [lwk_pkg::DATA_W-1:0] RDATA,
	// wake pin
	input wire logic                       MODE_SEL5_WAKE_OUT,
	input wire logic                       MODE_SEL5_WAKE_OE,
	// link status and causes
	input wire logic                       LINK_POWER_STATUS,
	input wire logic                       LINK_ON_PKT,
	input wire logic                       BUS_RESET,
	input wire logic                       PORT_EVENT_IRQ,
	input wire logic                       CONFIG_TIMEOUT_IRQ,
	input wire logic                       CABLE_POWER_STATUS_IRQ,
	input wire logic                       STATE_TIMEOUT_IRQ
);
	// ****
	// helper logic
	// ****
	logic [1:0]  ctrl_r;                               // shadow of the control register
	logic [15:0] cnt_r;                                // cycles since reset, saturating
	wire         irq_res = ctrl_r[1] & (CONFIG_TIMEOUT_IRQ | CABLE_POWER_STATUS_IRQ
		| STATE_TIMEOUT_IRQ);                          // gated resume causes
	wire         wk = MODE_SEL5_WAKE_OUT;              // short alias
	// shadow follows writes so link state is known without internals
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_r <= 2'h0;
			cnt_r <= 16'h0;
		end else begin
			if (WR && ADDR == lwk_pkg::OFS_CTRL) ctrl_r <= WDATA[1:0];
			if (cnt_r != 16'hFFFF) cnt_r <= cnt_r + 16'h1;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// ****
	// properties
	// ****
	property p_rise_gap; $rose(wk) |-> !$past(wk, 2) && !$past(wk, 3) && !$past(wk, 4); endproperty
	a_rise_gap: assert property (p_rise_gap) else $error("wake low phase short");
	property p_high_len; wk [*4] |=> !wk; endproperty
	a_high_len: assert property (p_high_len) else $error("wake high phase long");
	property p_oe_hold; $rose(RST_N) |-> !MODE_SEL5_WAKE_OE [*4]; endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("pin driven at reset");
	property p_out_oe; wk |-> MODE_SEL5_WAKE_OE; endproperty
	a_out_oe: assert property (p_out_oe) else $error("wake high undriven");
	property p_link_stop; (LINK_POWER_STATUS && ctrl_r[0]) [*6] |-> !wk; endproperty
	a_link_stop: assert property (p_link_stop) else $error("wake with link active");
	property p_pei_wake; (PORT_EVENT_IRQ && !ctrl_r[0] && cnt_r > 16'h8) [*8] |-> ##[0:8] wk;
	endproperty
	a_pei_wake: assert property (p_pei_wake) else $error("no wake on port event");
	property p_res_wake; (irq_res && !ctrl_r[0] && cnt_r > 16'h8) [*8] |-> ##[0:8] wk;
	endproperty
	a_res_wake: assert property (p_res_wake) else $error("no wake on resume");
	property p_pkt_wake; LINK_ON_PKT && !BUS_RESET && !ctrl_r[0] && cnt_r > 16'h8
		##1 (!BUS_RESET && !ctrl_r[0]) [*6] |-> ##[0:4] wk; endproperty
	a_pkt_wake: assert property (p_pkt_wake) else $error("no wake on packet");
	property p_bus_stop; BUS_RESET && !PORT_EVENT_IRQ && !irq_res
		&& cnt_r > PWR_TIMEOUT_CYC + 8 |-> ##2 !wk [*2]; endproperty
	a_bus_stop: assert property (p_bus_stop) else $error("wake kept on bus reset");
	property p_rd_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule : lwk_link_wake_props

bind lwk_link_wake lwk_link_wake_props #(.PWR_TIMEOUT_CYC(PWR_TIMEOUT_CYC)) u_props (
	.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.MODE_SEL5_WAKE_OUT(MODE_SEL5_WAKE_OUT), .MODE_SEL5_WAKE_OE(MODE_SEL5_WAKE_OE),
	.LINK_POWER_STATUS(LINK_POWER_STATUS), .LINK_ON_PKT(LINK_ON_PKT), .BUS_RESET(BUS_RESET),
	.PORT_EVENT_IRQ(PORT_EVENT_IRQ), .CONFIG_TIMEOUT_IRQ(CONFIG_TIMEOUT_IRQ),
	.CABLE_POWER_STATUS_IRQ(CABLE_POWER_STATUS_IRQ), .STATE_TIMEOUT_IRQ(STATE_TIMEOUT_IRQ));

`default_nettype wire

// >>> lwk_llc_model.sv
// link layer model: powers up after it has seen the wake wave
`timescale 1ns/100ps
`default_nettype none

module lwk_llc_model #(
	parameter int DELAY = 3                 // wake high cycles before power-up
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// wake pin and bench control
	input  wire logic wake,
	input  wire logic allow,
	output logic      link_power_status
);
	int cnt;                                // wake high cycles seen
	// power stays up once reached; dropping allow powers the link down
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			link_power_status <= 1'b0;
		end else if (!allow) begin
			cnt <= 0;
			link_power_status <= 1'b0;
		end else if (wake) begin
			cnt <= cnt + 1;
			if (cnt >= DELAY) link_power_status <= 1'b1;
		end
	end
endmodule : lwk_llc_model

`default_nettype wire

// >>> tb.sv
// self-checking bench for the link wake block
`timescale 1ns/100ps
`default_nettype none

module tb;
	// ****
	// signals
	// ****
	localparam int TMO = 20;                         // shortened power-cycle limit
	logic        clk = 1'b0;                         // 25 MHz
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [5:0]  strap = 6'h00;                      // sel5..sel0
	logic        pkt = 1'b0;
	logic        brst = 1'b0;
	logic [3:0]  irqs = 4'h0;                        // sto, cps, cto, pei
	logic        allow = 1'b0;                       // lets the link model power up
	wire  [31:0] rdata;
	wire  [5:0]  mode;
	wire  [2:0]  pclass;
	wire         irq, wout, woe, link_power_status, pin;
	int          n_fail = 0, total_checks = 0, seed = 84, exp_isr = 0;
	logic [31:0] d;
	assign pin = woe ? wout : strap[5];              // strap drives while pin is released
	always #20 clk = ~clk;
	lwk_link_wake #(.PWR_TIMEOUT_CYC(TMO)) u_lwk_link_wake (.CLK(clk), .RST_N(rst_n),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
		.PORT_MODE_SEL_BIT3(strap[3]), .PORT_MODE_SEL_BIT4(strap[4]),
		.MODE_SEL2_POWER_CLASS0(strap[2]), .MODE_SEL1_POWER_CLASS1(strap[1]),
		.MODE_SEL0_POWER_CLASS2(strap[0]), .MODE_SEL5_WAKE_IN(pin),
		.MODE_SEL5_WAKE_OUT(wout), .MODE_SEL5_WAKE_OE(woe), .LINK_POWER_STATUS(link_power_status),
		.LINK_ON_PKT(pkt), .BUS_RESET(brst), .PORT_EVENT_IRQ(irqs[0]),
		.CONFIG_TIMEOUT_IRQ(irqs[1]), .CABLE_POWER_STATUS_IRQ(irqs[2]),
		.STATE_TIMEOUT_IRQ(irqs[3]), .PORT_MODE_STRAP(mode), .POWER_CLASS(pclass));
	lwk_llc_model #(.DELAY(3)) u_lwk_llc_model (.clk(clk), .rst_n(rst_n), .wake(pin),
		.allow(allow), .link_power_status(link_power_status));
	// ****
	// tasks
	// ****
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg
	// read data stand only in the cycle after the strobe
	task rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	task pulse(input logic bus);
		@(posedge clk);
		if (bus) brst <= 1'b1;
		else pkt <= 1'b1;
		@(posedge clk);
		pkt <= 1'b0;
		brst <= 1'b0;
	endtask : pulse
	// expects the wake output high at some sample within n cycles, or never
	task saw(input int n, input logic e);
		logic s;
		s = 1'b0;
		repeat (n) begin
			step(1);
			if (wout === 1'b1) s = 1'b1;
		end
		chk(32'(s), 32'(e));
	endtask : saw
	// measures one full high and low phase of the wave
	task wave;
		int h, l, n;
		h = 0;
		l = 0;
		n = 0;
		while (wout !== 1'b1 && n < 20) begin step(1); n++; end
		while (wout === 1'b1 && h < 20) begin step(1); h++; end
		while (wout === 1'b0 && l < 20) begin step(1); l++; end
		chk(h, lwk_pkg::WAKE_HALF_CYC);
		chk(l, lwk_pkg::WAKE_HALF_CYC);
	endtask : wave
	// reset with given straps; every reset counts as a power cycle
	task do_reset(input logic [5:0] s);
		logic [2:0] pc;
		logic       w;
		pc = (s[4:3] == 2'h3) ? 3'h0 : s[2:0];
		w = (pc <= 3'h4);
		@(posedge clk);
		rst_n <= 1'b0;
		strap <= s;
		repeat (5) @(posedge clk);
		chk(32'(woe), 32'h0);
		rst_n <= 1'b1;
		saw(40, w);
		saw(8, 1'b0);
		chk(32'(mode), 32'(s));
		chk(32'(pclass), 32'(pc));
		chk(32'(woe), 32'h1);
		exp_isr = w ? 7 : 0;
		rd_reg(lwk_pkg::OFS_ISR, d);
		chk(d, exp_isr);
		chk(32'(irq), 32'h0);
		wr_reg(lwk_pkg::OFS_IMR, 32'h7);
		chk(32'(irq), 32'(exp_isr != 0));
		wr_reg(lwk_pkg::OFS_ISR, 32'h7);
		wr_reg(lwk_pkg::OFS_IMR, 32'h0);
		chk(32'(irq), 32'h0);
	endtask : do_reset
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	// ****
	// main sequence
	// ****
	initial begin
		for (int i = 0; i < 4; i++) do_reset(i == 0 ? 6'h07 : i == 1 ? 6'h1B : 6'($random(seed)));
		pulse(1'b0);
		wave();
		pulse(1'b1);
		step(2);
		saw(12, 1'b0);
		@(posedge clk) irqs <= 4'h1;
		saw(20, 1'b1);
		pulse(1'b1);
		saw(20, 1'b1);
		@(posedge clk) irqs <= 4'h0;
		saw(20, 1'b1);
		@(posedge clk) allow <= 1'b1;
		wr_reg(lwk_pkg::OFS_CTRL, 32'h1);
		step(20);
		saw(20, 1'b0);
		rd_reg(lwk_pkg::OFS_STAT, d);
		chk(32'(d[1:0]), 32'h2);
		@(posedge clk) irqs <= 4'h1;
		saw(20, 1'b0);
		wr_reg(lwk_pkg::OFS_CTRL, 32'h0);
		saw(20, 1'b1);
		@(posedge clk) irqs <= 4'h0;
		wr_reg(lwk_pkg::OFS_CTRL, 32'h1);
		step(10);
		pulse(1'b0);
		wr_reg(lwk_pkg::OFS_CTRL, 32'h0);
		saw(20, 1'b0);
		// each timeout cause wakes only with the resume enable set
		for (int k = 1; k < 4; k++) begin
			@(posedge clk) irqs <= 4'h1 << k;
			saw(20, 1'b0);
			wr_reg(lwk_pkg::OFS_CTRL, 32'h2);
			saw(20, 1'b1);
			@(posedge clk) irqs <= 4'h0;
			wr_reg(lwk_pkg::OFS_CTRL, 32'h3);
			step(10);
			saw(10, 1'b0);
			wr_reg(lwk_pkg::OFS_CTRL, 32'h0);
		end
		exp_isr = 3;
		rd_reg(8'h10, d);
		chk(d, 32'h0);
		rd_reg(lwk_pkg::OFS_ISR, d);
		chk(d, exp_isr);
		chk(32'(irq), 32'h0);
		wr_reg(lwk_pkg::OFS_IMR, 32'h2);
		chk(32'(irq), 32'h1);
		wr_reg(lwk_pkg::OFS_ISR, 32'h3);
		rd_reg(lwk_pkg::OFS_ISR, d);
		chk(d, 32'h0);
		chk(32'(irq), 32'h0);
		finish_test();
	end
	// watchdog well past the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		finish_test();
	end
endmodule : tb

`default_nettype wire
